/* src/usl_regs.svh */
// register map, field positions, reset values and timing counts
`ifndef USL_REGS_SVH
`define USL_REGS_SVH
// ==========================================
// register offsets (byte addresses)
`define USL_OFF_CTRL    8'h00
`define USL_OFF_MODE    8'h04
`define USL_OFF_MASK    8'h08
`define USL_OFF_STAT    8'h0C
`define USL_OFF_RXD     8'h10
`define USL_OFF_TXD     8'h14
`define USL_OFF_BAUD    8'h18
`define USL_OFF_ISOERR  8'h1C
`define USL_OFF_LINMODE 8'h20
`define USL_OFF_LIN_FRAME_IDENTIFIER   8'h24
// ==========================================
// control command bits
`define USL_CR_RXSRST   0
`define USL_CR_FLOW_REQUEST_ENABLE_CMD    18
`define USL_CR_FLOW_REQUEST_DISABLE_CMD   19
// ==========================================
// status / mask bits
`define USL_ST_W        5
`define USL_ST_RXRDY    0
`define USL_ST_TXDONE   1
`define USL_ST_LIN_FRAME_IDENTIFIER    2
`define USL_ST_OVRE     3
`define USL_ST_FRAME    4
// ==========================================
// reset values and timing
`define USL_BAUD_RST    16'h0001
`define USL_OVS_MID     4'h7
`define USL_OVS_LAST    4'hF
`define USL_FRAME_BITS  4'hA
`define USL_BREAK_BITS  4'hE
`define USL_SYNC_BYTE   8'h55
`define USL_BIT_LAST    3'h7
`endif

/* src/usl_pkg.sv */
// shared types of the serial transceiver
package usl_pkg;
  // ==========================================
  // operating modes held in the serial mode register
  typedef enum logic [2:0] {
    USL_MODE_NORMAL     = 3'b000,
    USL_MODE_HANDSHAKE  = 3'b001,
    USL_MODE_LIN_MASTER = 3'b010,
    USL_MODE_LIN_SLAVE  = 3'b011,
    USL_MODE_ISO_T1     = 3'b100
  } usl_mode_t;
  // transmit sequencer states
  typedef enum logic [2:0] {
    USL_TX_IDLE  = 3'b000,
    USL_TX_BREAK = 3'b001,
    USL_TX_SYNC  = 3'b010,
    USL_TX_ID    = 3'b011,
    USL_TX_DATA  = 3'b100
  } usl_tx_state_t;
  // receiver states
  typedef enum logic [2:0] {
    USL_RX_IDLE  = 3'b000,
    USL_RX_START = 3'b001,
    USL_RX_DATA  = 3'b010,
    USL_RX_STOP  = 3'b011,
    USL_RX_WAIT  = 3'b100
  } usl_rx_state_t;
endpackage

/* src/usl_rx_if.sv */
// link between the control core and the receiver
`timescale 1ns/1ps
interface usl_rx_if;
  logic       srst;  // receiver soft reset pulse
  logic       en;    // receiver enable
  logic       tick;  // 16x oversampling enable
  logic       line;  // serial input level
  logic [7:0] data;  // received byte
  logic       valid; // one-cycle byte strobe
  logic       ferr;  // stop bit found low
  modport rx  (input srst, en, tick, line, output data, valid, ferr);
  modport ctl (output srst, en, tick, line, input data, valid, ferr);
endinterface

/* src/usl_baud.sv */
// baud divider: 16x oversampling enable and bit-rate enable
`timescale 1ns/1ps
`include "usl_regs.svh"
module usl_baud #(
  parameter int DIV_W = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick16,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_reg; // divider count
  logic [3:0]       sub_reg; // oversample phase
  // ==========================================
  // divider; a zero divisor runs at clock rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick16  <= 1'b0;
    end else if (cnt_reg == '0 || cnt_reg >= div) begin
      cnt_reg <= {{(DIV_W-1){1'b0}}, 1'b1};
      tick16  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick16  <= 1'b0;
    end
  end
  // ==========================================
  // bit-rate enable: every sixteenth oversampling tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_reg <= 4'h0;
      tick    <= 1'b0;
    end else begin
      tick <= tick16 && (sub_reg == `USL_OVS_LAST);
      if (tick16)
        sub_reg <= sub_reg + 4'h1;
    end
  end
endmodule

/* src/usl_rx.sv */
// oversampling receiver for one 8N1 character
`timescale 1ns/1ps
`include "usl_regs.svh"
module usl_rx (
  input wire logic pclk,
  input wire logic presetn,
  usl_rx_if.rx     rif
);
  usl_pkg::usl_rx_state_t st_reg;  // receiver state
  logic [3:0]             ovs_reg; // oversample count
  logic [2:0]             bit_reg; // data bit index
  logic [7:0]             sh_reg;  // shift register
  // ==========================================
  // receive sequence; soft reset returns to idle at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= usl_pkg::USL_RX_IDLE;
      ovs_reg   <= 4'h0;
      bit_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      rif.data  <= 8'h00;
      rif.valid <= 1'b0;
      rif.ferr  <= 1'b0;
    end else begin
      rif.valid <= 1'b0;
      if (rif.srst || !rif.en) begin // RL10
        st_reg  <= usl_pkg::USL_RX_IDLE;
        ovs_reg <= 4'h0;
      end else begin
        case (st_reg)
          usl_pkg::USL_RX_IDLE: begin
            // falling line marks a possible start bit
            if (!rif.line) begin
              st_reg  <= usl_pkg::USL_RX_START;
              ovs_reg <= 4'h0;
            end
          end
          usl_pkg::USL_RX_START: begin
            if (rif.tick) begin
              ovs_reg <= ovs_reg + 4'h1;
              if (ovs_reg == `USL_OVS_MID) begin
                // a glitch shorter than half a bit is dropped
                st_reg  <= rif.line ? usl_pkg::USL_RX_IDLE
                                    : usl_pkg::USL_RX_DATA;
                ovs_reg <= 4'h0;
                bit_reg <= 3'h0;
              end
            end
          end
          usl_pkg::USL_RX_DATA: begin
            if (rif.tick) begin
              ovs_reg <= ovs_reg + 4'h1;
              if (ovs_reg == `USL_OVS_LAST) begin
                sh_reg  <= {rif.line, sh_reg[7:1]};
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == `USL_BIT_LAST)
                  st_reg <= usl_pkg::USL_RX_STOP;
              end
            end
          end
          usl_pkg::USL_RX_STOP: begin
            if (rif.tick) begin
              ovs_reg <= ovs_reg + 4'h1;
              if (ovs_reg == `USL_OVS_LAST) begin
                rif.data  <= sh_reg;
                rif.valid <= 1'b1;
                rif.ferr  <= !rif.line;
                // a break keeps the line low: wait for release
                st_reg    <= rif.line ? usl_pkg::USL_RX_IDLE
                                      : usl_pkg::USL_RX_WAIT;
              end
            end
          end
          usl_pkg::USL_RX_WAIT: begin
            if (rif.line)
              st_reg <= usl_pkg::USL_RX_IDLE;
          end
          default: st_reg <= usl_pkg::USL_RX_IDLE;
        endcase
      end
    end
  end
  // soft reset always lands in idle on the next edge
  a_srst_rx_idle: assert property (@(posedge pclk) disable iff (!presetn)
    rif.srst |=> st_reg == usl_pkg::USL_RX_IDLE && !rif.valid) // RL10
    else $error("receiver not idle after soft reset");
endmodule

/* src/usl_top.sv */
// serial transceiver core: APB registers, LIN header, flow control
//
// Overview of operation
// RL1: handshake mode keeps RTS low on full buffer
// RL2: flow request disable command drives RTS high
// RL3: flow request enable command drives RTS low
// RL4: DMA mode 0: identifier register write launches header
// RL5: identifier interrupt only on received headers
// RL6: DMA mode 1 in LIN: transfer never starts
// RL7: ISO error count register always reads zero
// RL8: ISO T1: receiver dead after transmit until reset
// RL9: software handler drives RTS around DMA buffers
// RL10: receiver soft reset leaves transmit, configuration intact
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "usl_regs.svh"
module usl_top #(
  parameter int   DIV_W        = 16,
  parameter logic RTS_HS_FIXED = 1'b0 // 1: intended handshake behaviour
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             rts,
  output logic             irq,
  output logic             dma_tx_req,
  input  wire logic        dma_tx_wr,
  input  wire logic [7:0]  dma_tx_data,
  input  wire logic        dma_tx_armed,
  output logic             dma_rx_req,
  input  wire logic        dma_rx_ack,
  output logic [7:0]       dma_rx_data,
  input  wire logic        dma_rx_full
);
  // ==========================================
  // register state
  usl_pkg::usl_mode_t     mode_reg;       // serial_mode_reg
  logic                   lin_dma_mode_select; // lin_mode_reg bit 0
  logic [`USL_ST_W-1:0]   mask_reg;       // interrupt mask
  logic [`USL_ST_W-1:0]   stat_reg;       // sticky status
  logic [`USL_ST_W-1:0]   stat_ev;        // this cycle's events
  logic [DIV_W-1:0]       baud_reg;       // baud divisor
  logic [7:0]             lin_id_reg;     // lin_identifier_reg
  logic                   id_pend_reg;    // header waiting to go
  logic                   hdr_sent_reg;   // header out, data may follow
  logic [7:0]             rx_data_reg;    // received byte
  logic                   rx_full_reg;    // received byte unread
  logic [1:0]             hdr_ph_reg;     // slave header phase
  logic [7:0]             tx_hold_reg;    // transmit holding byte
  logic                   tx_full_reg;    // holding byte valid
  logic                   rts_reg;        // software flow request
  logic                   iso_lock_reg;   // T1 receiver lock
  // transmit path
  usl_pkg::usl_tx_state_t tx_st_reg;      // sequencer state
  usl_pkg::usl_tx_state_t tx_st_next;
  logic [13:0]            tx_sh_reg;      // outgoing bits, lsb first
  logic [3:0]             tx_left_reg;    // bits still to send
  logic                   tx_ld;          // load shifter
  logic [13:0]            tx_ld_word;
  logic [3:0]             tx_ld_len;
  logic                   tx_take;        // holding byte consumed
  // bus decode
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   lin_mode;
  logic                   lin_master;
  logic                   tick16;
  logic                   tick;
  usl_rx_if               rif ();

  assign lin_master = (mode_reg == usl_pkg::USL_MODE_LIN_MASTER);
  assign lin_mode   = lin_master ||
                      (mode_reg == usl_pkg::USL_MODE_LIN_SLAVE);
  // ==========================================
  // APB slave: zero wait states, error on unmapped address
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    case (paddr)
      `USL_OFF_CTRL:    prdata = 32'h0000_0000; // commands only
      `USL_OFF_MODE:    prdata[2:0] = mode_reg;
      `USL_OFF_MASK:    prdata[`USL_ST_W-1:0] = mask_reg;
      `USL_OFF_STAT:    prdata[`USL_ST_W-1:0] = stat_reg;
      `USL_OFF_RXD:     prdata[7:0] = rx_data_reg;
      `USL_OFF_TXD:     prdata[7:0] = tx_hold_reg;
      `USL_OFF_BAUD:    prdata[DIV_W-1:0] = baud_reg;
      `USL_OFF_ISOERR:  prdata = 32'h0000_0000; // RL7
      `USL_OFF_LINMODE: prdata[0] = lin_dma_mode_select;
      `USL_OFF_LIN_FRAME_IDENTIFIER:   prdata[7:0] = lin_id_reg;
      default:          pslverr = psel && penable;
    endcase
  end
  // ==========================================
  // configuration registers; receiver soft reset leaves them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg            <= usl_pkg::USL_MODE_NORMAL;
      lin_dma_mode_select <= 1'b0;
      mask_reg            <= '0;
      baud_reg            <= `USL_BAUD_RST;
    end else if (wr_acc) begin // RL10
      case (paddr)
        `USL_OFF_MODE:    mode_reg <= usl_pkg::usl_mode_t'(pwdata[2:0]);
        `USL_OFF_MASK:    mask_reg <= pwdata[`USL_ST_W-1:0];
        `USL_OFF_BAUD:    baud_reg <= pwdata[DIV_W-1:0];
        `USL_OFF_LINMODE: lin_dma_mode_select <= pwdata[0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // flow request pin: software commands, handshake mode override
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rts_reg <= 1'b0;
    else if (wr_acc && paddr == `USL_OFF_CTRL) begin
      if (pwdata[`USL_CR_FLOW_REQUEST_DISABLE_CMD])
        rts_reg <= 1'b1; // RL2 RL9
      else if (pwdata[`USL_CR_FLOW_REQUEST_ENABLE_CMD])
        rts_reg <= 1'b0; // RL3 RL9
    end
  end
  // with RTS_HS_FIXED at 0 the pin never rises in handshake mode
  assign rts = (mode_reg == usl_pkg::USL_MODE_HANDSHAKE)
             ? (RTS_HS_FIXED & dma_rx_full) : rts_reg; // RL1
  // ==========================================
  // receive side: soft reset, byte holding, LIN slave header
  assign rif.srst = wr_acc && paddr == `USL_OFF_CTRL &&
                    pwdata[`USL_CR_RXSRST];
  assign rif.en   = !iso_lock_reg;
  assign rif.tick = tick16;
  assign rif.line = rxd;
  assign dma_rx_req  = rx_full_reg;
  assign dma_rx_data = rx_data_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      hdr_ph_reg  <= 2'b00;
    end else if (rif.srst) begin // RL10
      rx_full_reg <= 1'b0;
      hdr_ph_reg  <= 2'b00;
    end else begin
      if (dma_rx_ack || (rd_acc && paddr == `USL_OFF_RXD))
        rx_full_reg <= 1'b0;
      if (rif.valid) begin
        if (mode_reg == usl_pkg::USL_MODE_LIN_SLAVE &&
            rif.ferr && rif.data == 8'h00)
          hdr_ph_reg <= 2'b01; // break seen, sync next
        else if (hdr_ph_reg == 2'b01)
          hdr_ph_reg <= 2'b10; // sync byte, identifier next
        else if (hdr_ph_reg == 2'b10)
          hdr_ph_reg <= 2'b00; // identifier taken below
        else begin
          rx_data_reg <= rif.data;
          rx_full_reg <= 1'b1;
        end
      end
    end
  end
  // ==========================================
  // identifier register: written by software or a received header
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lin_id_reg  <= 8'h00;
      id_pend_reg <= 1'b0;
    end else begin
      if (wr_acc && paddr == `USL_OFF_LIN_FRAME_IDENTIFIER) begin
        lin_id_reg  <= pwdata[7:0];
        id_pend_reg <= lin_master; // RL4
      end else if (tx_st_reg == usl_pkg::USL_TX_IDLE &&
                   tx_st_next == usl_pkg::USL_TX_BREAK)
        id_pend_reg <= 1'b0;
      if (rif.valid && hdr_ph_reg == 2'b10)
        lin_id_reg <= rif.data;
    end
  end
  // ==========================================
  // transmit holding byte from the bus or the DMA channel
  // mode 1 in LIN leaves the channel unserved, as on this silicon
  assign dma_tx_req = !tx_full_reg &&
                      !(lin_mode && lin_dma_mode_select); // RL6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end else if (wr_acc && paddr == `USL_OFF_TXD) begin
      tx_hold_reg <= pwdata[7:0];
      tx_full_reg <= 1'b1;
    end else if (dma_tx_wr && dma_tx_req) begin
      tx_hold_reg <= dma_tx_data; // never taken as identifier
      tx_full_reg <= 1'b1;        // RL4
    end else if (tx_take)
      tx_full_reg <= 1'b0;
  end
  // ==========================================
  // transmit sequencer: header (break, sync, id) then data
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_ld      = 1'b0;
    tx_ld_word = {4'hF, 1'b1, tx_hold_reg, 1'b0};
    tx_ld_len  = `USL_FRAME_BITS;
    tx_take    = 1'b0;
    if (tx_left_reg == 4'h0) begin
      case (tx_st_reg)
        usl_pkg::USL_TX_IDLE: begin
          // header waits for an armed channel in mode 0
          if (lin_master && id_pend_reg && dma_tx_armed &&
              !lin_dma_mode_select) begin // RL4
            tx_st_next = usl_pkg::USL_TX_BREAK;
            tx_ld      = 1'b1;
            tx_ld_word = 14'h2000;
            tx_ld_len  = `USL_BREAK_BITS;
          end else if (tx_full_reg && (!lin_master || hdr_sent_reg)) begin
            tx_st_next = usl_pkg::USL_TX_DATA;
            tx_ld      = 1'b1;
            tx_take    = 1'b1;
          end
        end
        usl_pkg::USL_TX_BREAK: begin
          tx_st_next = usl_pkg::USL_TX_SYNC;
          tx_ld      = 1'b1;
          tx_ld_word = {4'hF, 1'b1, `USL_SYNC_BYTE, 1'b0};
        end
        usl_pkg::USL_TX_SYNC: begin
          tx_st_next = usl_pkg::USL_TX_ID;
          tx_ld      = 1'b1;
          tx_ld_word = {4'hF, 1'b1, lin_id_reg, 1'b0};
        end
        usl_pkg::USL_TX_ID:   tx_st_next = usl_pkg::USL_TX_IDLE;
        usl_pkg::USL_TX_DATA: tx_st_next = usl_pkg::USL_TX_IDLE;
        default:              tx_st_next = usl_pkg::USL_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg    <= usl_pkg::USL_TX_IDLE;
      hdr_sent_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      if (wr_acc && paddr == `USL_OFF_LIN_FRAME_IDENTIFIER)
        hdr_sent_reg <= 1'b0;
      else if (tx_st_reg == usl_pkg::USL_TX_ID &&
               tx_st_next == usl_pkg::USL_TX_IDLE)
        hdr_sent_reg <= 1'b1;
    end
  end
  // ==========================================
  // bit shifter; pin changes only on bit-rate ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_reg   <= 14'h3FFF;
      tx_left_reg <= 4'h0;
      txd         <= 1'b1;
    end else if (tx_ld) begin
      tx_sh_reg   <= tx_ld_word;
      tx_left_reg <= tx_ld_len;
    end else if (tick && tx_left_reg != 4'h0) begin
      txd         <= tx_sh_reg[0];
      tx_sh_reg   <= {1'b1, tx_sh_reg[13:1]};
      tx_left_reg <= tx_left_reg - 4'h1;
    end
  end
  // ==========================================
  // T1 receiver lock as soon as any frame is loaded for sending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      iso_lock_reg <= 1'b0;
    else if (rif.srst)
      iso_lock_reg <= 1'b0; // RL8
    else if (mode_reg == usl_pkg::USL_MODE_ISO_T1 && tx_ld)
      iso_lock_reg <= 1'b1; // RL8
  end
  // ==========================================
  // sticky status, cleared by reading it; a new event wins
  always_comb begin
    stat_ev = '0;
    stat_ev[`USL_ST_RXRDY]  = rif.valid && hdr_ph_reg == 2'b00 &&
                              !(mode_reg == usl_pkg::USL_MODE_LIN_SLAVE &&
                                rif.ferr);
    stat_ev[`USL_ST_TXDONE] = tx_st_reg == usl_pkg::USL_TX_DATA &&
                              tx_st_next == usl_pkg::USL_TX_IDLE;
    // only a received header raises it; transmitted ones do not
    stat_ev[`USL_ST_LIN_FRAME_IDENTIFIER]  = rif.valid && hdr_ph_reg == 2'b10; // RL5
    stat_ev[`USL_ST_OVRE]   = stat_ev[`USL_ST_RXRDY] && rx_full_reg;
    stat_ev[`USL_ST_FRAME]  = rif.valid && rif.ferr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat_reg <= '0;
    else if (rd_acc && paddr == `USL_OFF_STAT)
      stat_reg <= stat_ev;
    else
      stat_reg <= stat_reg | stat_ev;
  end
  assign irq = |(stat_reg & mask_reg);
  // ==========================================
  // submodules
  usl_baud #(.DIV_W(DIV_W)) u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (baud_reg),
    .tick16  (tick16),
    .tick    (tick)
  );
  usl_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif.rx)
  );
  // ==========================================
  // checks
  a_rts_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `USL_OFF_CTRL && pwdata[`USL_CR_FLOW_REQUEST_DISABLE_CMD] &&
     mode_reg == usl_pkg::USL_MODE_NORMAL) |=> rts) // RL2
    else $error("rts not high after disable command");
  a_rts_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == `USL_OFF_CTRL && pwdata[`USL_CR_FLOW_REQUEST_ENABLE_CMD] &&
     !pwdata[`USL_CR_FLOW_REQUEST_DISABLE_CMD] && mode_reg == usl_pkg::USL_MODE_NORMAL)
    |=> !rts) // RL3
    else $error("rts not low after enable command");
  a_rts_hs_low: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reg == usl_pkg::USL_MODE_HANDSHAKE && !RTS_HS_FIXED)
    |-> !rts) // RL1
    else $error("rts high in handshake mode");
  a_isoerr_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == `USL_OFF_ISOERR) |-> prdata == 32'h0) // RL7
    else $error("iso error count read nonzero");
  a_dma_mode_one: assert property (@(posedge pclk) disable iff (!presetn)
    (lin_mode && lin_dma_mode_select) |-> !dma_tx_req) // RL6
    else $error("dma served with mode select at one");
  a_hdr_launch: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_st_reg == usl_pkg::USL_TX_IDLE &&
     tx_st_next == usl_pkg::USL_TX_BREAK)
    |-> id_pend_reg && dma_tx_armed && !lin_dma_mode_select
    ##1 tx_left_reg == `USL_BREAK_BITS) // RL4
    else $error("header launched without cause");
  a_lin_frame_identifier_rx_only: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stat_reg[`USL_ST_LIN_FRAME_IDENTIFIER]) |-> $past(hdr_ph_reg) == 2'b10) // RL5
    else $error("identifier flag without received header");
  a_srst_keeps_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    rif.srst |=> $stable(mode_reg) && !rx_full_reg &&
    ($past(tx_left_reg) < 4'h2 ||
     ($stable(tx_st_reg) && tx_left_reg != 4'h0))) // RL10
    else $error("soft reset disturbed config or transmit");
  a_iso_lock: assert property (@(posedge pclk) disable iff (!presetn)
    iso_lock_reg && !rif.srst |=> !rif.valid) // RL8
    else $error("T1 receiver delivered data while locked");
endmodule

/* tb/usl_node.sv */
// remote serial node: sends 8N1 characters into the receiver
`timescale 1ns/1ps
module usl_node (
  input wire logic pclk,
  output logic     rxd
);
  // ==========================================
  // line idles high between characters
  initial rxd = 1'h1;
  // start, eight data bits lsb first, stop; 16 clocks each at divisor 1
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rxd <= f[i];
      repeat (15) @(posedge pclk);
    end
  endtask
endmodule

/* tb/tb.sv */
// testbench: registers, flow request pin, receive path, LIN header
`timescale 1ns/1ps
`include "usl_regs.svh"
module tb;
  // ==========================================
  // stimulus and observed signals
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
  logic        penable = 1'h0, pwrite = 1'h0, armed = 1'h0, full = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, txd, rts, irq, rxd;
  logic        dma_tx_req, dma_rx_req, dma_wr = 1'h0;
  logic [7:0]  dma_rx_data, dma_data = 8'h00;
  int          fail_count = 0, check_count = 0, n;
  usl_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .rts(rts), .irq(irq), .dma_tx_req(dma_tx_req),
    .dma_tx_wr(dma_wr), .dma_tx_data(dma_data), .dma_tx_armed(armed),
    .dma_rx_req(dma_rx_req), .dma_rx_ack(1'h0),
    .dma_rx_data(dma_rx_data), .dma_rx_full(full));
  usl_node node (.pclk(pclk), .rxd(rxd));
  // 125 MHz clock
  always #4 pclk = ~pclk;
  // ==========================================
  // verdict, comparison and bus tasks
  task end_sim;
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tmo;
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one transfer; the idle edge first keeps psel from two writes at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 20) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  // ==========================================
  // scenarios
  task t_regs;
    apb(1'h0, `USL_OFF_ISOERR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h3C, 32'h0);
    chk(err, 1'h1);
  endtask
  // software flow control around a full receive buffer
  task t_rts;
    @(posedge pclk) full <= 1'h1;
    apb(1'h1, `USL_OFF_CTRL, 32'h0008_0000);
    chk(rts, 1'h1);
    @(posedge pclk) full <= 1'h0;
    apb(1'h1, `USL_OFF_CTRL, 32'h0004_0000);
    chk(rts, 1'h0);
  endtask
  // handshake mode overrides a raised request; silicon keeps it low
  task t_hs;
    apb(1'h1, `USL_OFF_CTRL, 32'h0008_0000);
    @(posedge pclk) full <= 1'h1;
    apb(1'h1, `USL_OFF_MODE, 32'h1);
    chk(rts, 1'h0);
    @(posedge pclk) full <= 1'h0;
  endtask
  // masked byte keeps irq low, unmasking raises it, status read clears
  task t_rx;
    apb(1'h1, `USL_OFF_MODE, 32'h0);
    node.send(8'hA5);
    for (n = 0; n < 64 && dma_rx_req !== 1'h1; n++) @(posedge pclk);
    if (n == 64) tmo();
    #1 chk(irq, 1'h0);
    apb(1'h1, `USL_OFF_MASK, 32'h1);
    chk(irq, 1'h1);
    apb(1'h0, `USL_OFF_RXD, 32'h0);
    chk(rd[7:0], 8'hA5);
    apb(1'h0, `USL_OFF_STAT, 32'h0);
    chk(rd[0], 1'h1);
    chk(irq, 1'h0);
  endtask
  // T1: a sent frame locks the receiver until soft reset; the mode is then rewritten
  task t_iso;
    apb(1'h1, `USL_OFF_MODE, 32'h4);
    apb(1'h1, `USL_OFF_TXD, 32'h3C);
    node.send(8'h5A);
    #1 chk(dma_rx_req, 1'h0);
    apb(1'h1, `USL_OFF_CTRL, 32'h1);
    apb(1'h1, `USL_OFF_MODE, 32'h4);
    apb(1'h1, `USL_OFF_CTRL, 32'h0);
    node.send(8'h5A);
    #1 chk(dma_rx_req, 1'h1);
    apb(1'h0, `USL_OFF_RXD, 32'h0);
    chk(rd[7:0], 8'h5A);
  endtask
  // identifier write launches the header; no identifier event on send
  task t_lin;
    apb(1'h1, `USL_OFF_MODE, 32'h2);
    apb(1'h1, `USL_OFF_LINMODE, 32'h0);
    // first channel word must not become the identifier
    @(posedge pclk) dma_wr <= 1'h1;
    dma_data <= 8'h11;
    @(posedge pclk) dma_wr <= 1'h0;
    @(posedge pclk) armed <= 1'h1;
    apb(1'h1, `USL_OFF_LIN_FRAME_IDENTIFIER, 32'h2A);
    for (n = 0; n < 100 && txd !== 1'h0; n++) @(posedge pclk);
    if (n == 100) tmo();
    // skip break and sync, then sample the identifier mid-bit
    repeat (24 * 16 + 8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      rd[i] = txd;
    end
    chk(rd[7:0], 8'h2A);
    repeat (16) @(posedge pclk);
    apb(1'h0, `USL_OFF_STAT, 32'h0);
    chk(rd[2], 1'h0);
    apb(1'h1, `USL_OFF_CTRL, 32'h1);
    apb(1'h0, `USL_OFF_MODE, 32'h0);
    chk(rd[2:0], 3'h2);
  endtask
  // reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_rts();
    t_hs();
    t_rx();
    t_iso();
    t_lin();
    end_sim();
  end
endmodule
